// ---- core/tss_pkg.sv ----
// package: constants and types for the trigger step sequencer
package tss_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // widths and sizes
  localparam int STEP_W     = 8;
  localparam int QPTR_W     = 5;
  localparam int QDEPTH     = 32;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 16;
  localparam int TRIG_IN_N  = 16;
  localparam int IRQ_N      = 16;
  localparam int TRIG_OUT_N = 32;
  localparam int CHSEL_W    = 5;

  ////////////////////////////////////////////////////////////////////////////
  // register offsets on the plain register port
  localparam logic [ADDR_W-1:0] OFS_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_STATUS     = 8'h01;
  localparam logic [ADDR_W-1:0] OFS_QPTR       = 8'h02;
  localparam logic [ADDR_W-1:0] OFS_ADJUST     = 8'h03;
  localparam logic [ADDR_W-1:0] OFS_HOLD       = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_LIMIT0     = 8'h05;
  localparam logic [ADDR_W-1:0] OFS_LIMIT1     = 8'h06;
  localparam logic [ADDR_W-1:0] OFS_COUNT0     = 8'h07;
  localparam logic [ADDR_W-1:0] OFS_COUNT1     = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_CHSEL      = 8'h09;
  localparam logic [2:0]        OFS_QUEUE_PFX  = 3'h1;

  // field positions
  localparam int CTRL_RUN_BIT   = 0;
  localparam int STAT_BUSY_BIT  = 0;
  localparam int STAT_WAIT_BIT  = 1;
  localparam int STAT_QPTR_LSB  = 8;
  localparam int COPY_SEL_BIT   = 3;

  // values after reset
  localparam logic [DATA_W-1:0]  RST_DATA  = 16'h0000;
  localparam logic [QPTR_W-1:0]  RST_QPTR  = 5'h00;
  localparam logic [CHSEL_W-1:0] RST_CHSEL = 5'h00;

  ////////////////////////////////////////////////////////////////////////////
  // step opcodes, full and three-bit prefixes
  localparam logic [3:0] OP_CONTROL   = 4'h0;
  localparam logic [3:0] OP_ADD_COPY  = 4'h1;
  localparam logic [3:0] OP_WAIT_RISE = 4'h4;
  localparam logic [3:0] OP_WAIT_FALL = 4'h5;
  localparam logic [3:0] OP_RESERVED  = 4'h6;
  localparam logic [3:0] OP_IRQ       = 4'h7;
  localparam logic [2:0] PFX_CHANNEL  = 3'h1;
  localparam logic [2:0] PFX_TRIGGER  = 3'h4;
  localparam logic [2:0] PFX_JUMP     = 3'h5;
  localparam logic [2:0] PFX_LOOP0    = 3'h6;
  localparam logic [2:0] PFX_LOOP1    = 3'h7;

  // control step options and add/copy targets
  localparam logic [3:0] CTL_HALT     = 4'h1;
  localparam logic [2:0] TGT_LIMIT0   = 3'h0;
  localparam logic [2:0] TGT_LIMIT1   = 3'h1;

  ////////////////////////////////////////////////////////////////////////////
  // types
  typedef struct packed {
    logic [3:0] op;
    logic [3:0] arg;
  } tss_step_t;

  typedef enum logic [3:0] {
    ST_IDLE  = 4'b0001,
    ST_FETCH = 4'b0010,
    ST_EXEC  = 4'b0100,
    ST_WAIT  = 4'b1000
  } tss_state_t;

endpackage

// ---- core/tss_step_mem.sv ----
// step queue memory: one write port, one registered read port
`timescale 1ns/1ns
module tss_step_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 32,
  parameter int AW    = 5
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             wr_en_in,
  input  wire logic [AW-1:0]    wr_addr_in,
  input  wire logic [WIDTH-1:0] wr_data_in,
  input  wire logic [AW-1:0]    rd_addr_in,
  output logic      [WIDTH-1:0] rd_data_out
);

  logic [WIDTH-1:0] mem_reg [DEPTH];

  always_ff @(posedge clk_in) begin
    if (wr_en_in) begin
      mem_reg[wr_addr_in] <= wr_data_in;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rd_data_out <= '0;
    end else begin
      rd_data_out <= mem_reg[rd_addr_in];
    end
  end

endmodule

// ---- core/tss_sequencer.sv ----
// trigger step sequencer: step fetch, decode and execution with register port
`timescale 1ns/1ns
module tss_sequencer (
  input  wire logic                              CLK_IN,
  input  wire logic                              RST_N_IN,
  input  wire logic [tss_pkg::ADDR_W-1:0]        BUS_ADDR_IN,
  input  wire logic [tss_pkg::DATA_W-1:0]        BUS_WDATA_IN,
  input  wire logic                              BUS_WR_IN,
  input  wire logic                              BUS_RD_IN,
  output logic      [tss_pkg::DATA_W-1:0]        BUS_RDATA_OUT,
  input  wire logic [tss_pkg::TRIG_IN_N-1:0]     TRIG_SRC_IN,
  output logic      [tss_pkg::IRQ_N-1:0]         IRQ_OUT,
  output logic      [tss_pkg::TRIG_OUT_N-1:0]    TRIG_OUT,
  output logic      [tss_pkg::CHSEL_W-1:0]       ADC_CHANNEL_SELECT_OUT,
  output logic                                   BUSY_OUT
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  tss_pkg::tss_state_t                 state_reg;
  tss_pkg::tss_state_t                 state_next;
  tss_pkg::tss_step_t                  step_entry;
  logic [tss_pkg::STEP_W-1:0]          mem_rd_data;
  logic                                run_reg;
  logic [tss_pkg::QPTR_W-1:0]          queue_pointer_reg;
  logic [tss_pkg::QPTR_W-1:0]          queue_pointer_next;
  logic [tss_pkg::DATA_W-1:0]          adjust_value_reg;
  logic [tss_pkg::DATA_W-1:0]          hold_value_reg;
  logic [tss_pkg::DATA_W-1:0]          loop_limit0_reg;
  logic [tss_pkg::DATA_W-1:0]          loop_limit1_reg;
  logic [tss_pkg::DATA_W-1:0]          loop_counter0_reg;
  logic [tss_pkg::DATA_W-1:0]          loop_counter1_reg;
  logic [tss_pkg::CHSEL_W-1:0]         adc_channel_select_reg;
  logic [tss_pkg::IRQ_N-1:0]           irq_reg;
  logic [tss_pkg::TRIG_OUT_N-1:0]      trig_reg;
  logic [tss_pkg::TRIG_IN_N-1:0]       trig_prev_reg;
  logic [3:0]                          wait_sel_reg;
  logic                                wait_fall_reg;
  logic [tss_pkg::DATA_W-1:0]          rdata_reg;
  logic [tss_pkg::DATA_W-1:0]          rdata_next;
  logic                                exec;
  logic                                wr_ctrl;
  logic                                wr_queue;
  logic                                halt_step;
  logic                                is_wait;
  logic                                edge_seen;
  logic                                loop0_done;
  logic                                loop1_done;
  logic                                tgt_step;
  logic                                tgt_copy;
  logic [tss_pkg::TRIG_IN_N-1:0]       rise_vec;
  logic [tss_pkg::TRIG_IN_N-1:0]       fall_vec;

  ////////////////////////////////////////////////////////////////////////////
  // helper functions

  // five-bit field made of the opcode's low bit and the argument
  function automatic logic [4:0] step_index5(input tss_pkg::tss_step_t s);
    return {s.op[0], s.arg};
  endfunction

  // new target value for an add or copy step
  function automatic logic [tss_pkg::DATA_W-1:0] add_or_copy(
    input logic                        copy,
    input logic [tss_pkg::DATA_W-1:0]  cur,
    input logic [tss_pkg::DATA_W-1:0]  adj,
    input logic [tss_pkg::DATA_W-1:0]  hold
  );
    return copy ? hold : cur + adj;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // step queue memory

  tss_step_mem #(
    .WIDTH (tss_pkg::STEP_W),
    .DEPTH (tss_pkg::QDEPTH),
    .AW    (tss_pkg::QPTR_W)
  ) u_step_mem (
    .clk_in      (CLK_IN),
    .rst_n_in    (RST_N_IN),
    .wr_en_in    (wr_queue),
    .wr_addr_in  (BUS_ADDR_IN[tss_pkg::QPTR_W-1:0]),
    .wr_data_in  (BUS_WDATA_IN[tss_pkg::STEP_W-1:0]),
    .rd_addr_in  (queue_pointer_reg),
    .rd_data_out (mem_rd_data)
  );

  ////////////////////////////////////////////////////////////////////////////
  // decode

  assign step_entry = tss_pkg::tss_step_t'(mem_rd_data);
  assign exec       = (state_reg == tss_pkg::ST_EXEC);
  assign wr_ctrl    = BUS_WR_IN && (BUS_ADDR_IN == tss_pkg::OFS_CTRL);
  assign wr_queue   = BUS_WR_IN && (BUS_ADDR_IN[7:5] == tss_pkg::OFS_QUEUE_PFX);

  // control step, only the halt option acts
  assign halt_step  = exec && (step_entry.op == tss_pkg::OP_CONTROL)
                      && (step_entry.arg == tss_pkg::CTL_HALT);

  assign is_wait    = (step_entry.op == tss_pkg::OP_WAIT_RISE)
                      || (step_entry.op == tss_pkg::OP_WAIT_FALL);

  assign loop0_done = (loop_counter0_reg == loop_limit0_reg);
  assign loop1_done = (loop_counter1_reg == loop_limit1_reg);

  assign tgt_step   = exec && (step_entry.op == tss_pkg::OP_ADD_COPY);
  assign tgt_copy   = step_entry.arg[tss_pkg::COPY_SEL_BIT];

  // input edges against the previous sample
  assign rise_vec   = TRIG_SRC_IN & ~trig_prev_reg;
  assign fall_vec   = ~TRIG_SRC_IN & trig_prev_reg;
  assign edge_seen  = wait_fall_reg ? fall_vec[wait_sel_reg]
                                    : rise_vec[wait_sel_reg];

  ////////////////////////////////////////////////////////////////////////////
  // sequencing state and next queue pointer

  always_comb begin
    state_next         = state_reg;
    queue_pointer_next = queue_pointer_reg;
    unique case (state_reg)
      tss_pkg::ST_IDLE: begin
        if (run_reg) begin
          state_next = tss_pkg::ST_FETCH;
        end
      end
      tss_pkg::ST_FETCH: begin
        state_next = run_reg ? tss_pkg::ST_EXEC : tss_pkg::ST_IDLE;
      end
      tss_pkg::ST_EXEC: begin
        queue_pointer_next = queue_pointer_reg + 5'h01;
        if (step_entry.op[3:1] == tss_pkg::PFX_JUMP) begin
          queue_pointer_next = step_index5(step_entry);
        end else if (step_entry.op[3:1] == tss_pkg::PFX_LOOP0 && !loop0_done) begin
          queue_pointer_next = step_index5(step_entry);
        end else if (step_entry.op[3:1] == tss_pkg::PFX_LOOP1 && !loop1_done) begin
          queue_pointer_next = step_index5(step_entry);
        end else if (is_wait) begin
          queue_pointer_next = queue_pointer_reg;
        end
        if (is_wait && run_reg) begin
          state_next = tss_pkg::ST_WAIT;
        end else if (run_reg && !halt_step) begin
          state_next = tss_pkg::ST_FETCH;
        end else begin
          state_next = tss_pkg::ST_IDLE;
        end
      end
      tss_pkg::ST_WAIT: begin
        if (!run_reg) begin
          state_next = tss_pkg::ST_IDLE;
        end else if (edge_seen) begin
          state_next         = tss_pkg::ST_FETCH;
          queue_pointer_next = queue_pointer_reg + 5'h01;
        end
      end
      default: begin
        state_next = tss_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      state_reg <= tss_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  // software may move the pointer only while idle
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      queue_pointer_reg <= tss_pkg::RST_QPTR;
    end else if (state_reg == tss_pkg::ST_IDLE) begin
      if (BUS_WR_IN && BUS_ADDR_IN == tss_pkg::OFS_QPTR) begin
        queue_pointer_reg <= BUS_WDATA_IN[tss_pkg::QPTR_W-1:0];
      end
    end else begin
      queue_pointer_reg <= queue_pointer_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // run control: a software write wins over a halt step

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      run_reg <= 1'b0;
    end else if (wr_ctrl) begin
      run_reg <= BUS_WDATA_IN[tss_pkg::CTRL_RUN_BIT];
    end else if (halt_step) begin
      run_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wait selection and input history

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      wait_sel_reg  <= 4'h0;
      wait_fall_reg <= 1'b0;
    end else if (exec && is_wait) begin
      wait_sel_reg  <= step_entry.arg;
      wait_fall_reg <= (step_entry.op == tss_pkg::OP_WAIT_FALL);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      trig_prev_reg <= '0;
    end else begin
      trig_prev_reg <= TRIG_SRC_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // plain value registers

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      adjust_value_reg <= tss_pkg::RST_DATA;
      hold_value_reg   <= tss_pkg::RST_DATA;
    end else if (BUS_WR_IN) begin
      if (BUS_ADDR_IN == tss_pkg::OFS_ADJUST) begin
        adjust_value_reg <= BUS_WDATA_IN;
      end
      if (BUS_ADDR_IN == tss_pkg::OFS_HOLD) begin
        hold_value_reg <= BUS_WDATA_IN;
      end
    end
  end

  // loop limits: add/copy targets, other targets are no-ops
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      loop_limit0_reg <= tss_pkg::RST_DATA;
    end else if (BUS_WR_IN && BUS_ADDR_IN == tss_pkg::OFS_LIMIT0) begin
      loop_limit0_reg <= BUS_WDATA_IN;
    end else if (tgt_step && step_entry.arg[2:0] == tss_pkg::TGT_LIMIT0) begin
      loop_limit0_reg <= add_or_copy(tgt_copy, loop_limit0_reg,
                                     adjust_value_reg, hold_value_reg);
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      loop_limit1_reg <= tss_pkg::RST_DATA;
    end else if (BUS_WR_IN && BUS_ADDR_IN == tss_pkg::OFS_LIMIT1) begin
      loop_limit1_reg <= BUS_WDATA_IN;
    end else if (tgt_step && step_entry.arg[2:0] == tss_pkg::TGT_LIMIT1) begin
      loop_limit1_reg <= add_or_copy(tgt_copy, loop_limit1_reg,
                                     adjust_value_reg, hold_value_reg);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // loop counters

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      loop_counter0_reg <= tss_pkg::RST_DATA;
    end else if (exec && step_entry.op[3:1] == tss_pkg::PFX_LOOP0) begin
      if (loop0_done) begin
        loop_counter0_reg <= tss_pkg::RST_DATA;
      end else begin
        loop_counter0_reg <= loop_counter0_reg + 16'h0001;
      end
    end else if (BUS_WR_IN && BUS_ADDR_IN == tss_pkg::OFS_COUNT0) begin
      loop_counter0_reg <= BUS_WDATA_IN;
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      loop_counter1_reg <= tss_pkg::RST_DATA;
    end else if (exec && step_entry.op[3:1] == tss_pkg::PFX_LOOP1) begin
      if (loop1_done) begin
        loop_counter1_reg <= tss_pkg::RST_DATA;
      end else begin
        loop_counter1_reg <= loop_counter1_reg + 16'h0001;
      end
    end else if (BUS_WR_IN && BUS_ADDR_IN == tss_pkg::OFS_COUNT1) begin
      loop_counter1_reg <= BUS_WDATA_IN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs toward the peripherals

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      adc_channel_select_reg <= tss_pkg::RST_CHSEL;
    end else if (exec && step_entry.op[3:1] == tss_pkg::PFX_CHANNEL) begin
      adc_channel_select_reg <= step_index5(step_entry);
    end
  end

  // one-cycle request pulses
  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      irq_reg <= '0;
    end else begin
      irq_reg <= '0;
      if (exec && step_entry.op == tss_pkg::OP_IRQ) begin
        irq_reg[step_entry.arg] <= 1'b1;
      end
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      trig_reg <= '0;
    end else begin
      trig_reg <= '0;
      if (exec && step_entry.op[3:1] == tss_pkg::PFX_TRIGGER) begin
        trig_reg[step_index5(step_entry)] <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register read port: data only in the cycle after the strobe

  always_comb begin
    rdata_next = '0;
    if (BUS_RD_IN) begin
      unique case (BUS_ADDR_IN)
        tss_pkg::OFS_CTRL: begin
          rdata_next[tss_pkg::CTRL_RUN_BIT] = run_reg;
        end
        tss_pkg::OFS_STATUS: begin
          rdata_next[tss_pkg::STAT_BUSY_BIT] = (state_reg != tss_pkg::ST_IDLE);
          rdata_next[tss_pkg::STAT_WAIT_BIT] = (state_reg == tss_pkg::ST_WAIT);
          rdata_next[tss_pkg::STAT_QPTR_LSB +: tss_pkg::QPTR_W] = queue_pointer_reg;
        end
        tss_pkg::OFS_QPTR:   rdata_next[tss_pkg::QPTR_W-1:0] = queue_pointer_reg;
        tss_pkg::OFS_ADJUST: rdata_next = adjust_value_reg;
        tss_pkg::OFS_HOLD:   rdata_next = hold_value_reg;
        tss_pkg::OFS_LIMIT0: rdata_next = loop_limit0_reg;
        tss_pkg::OFS_LIMIT1: rdata_next = loop_limit1_reg;
        tss_pkg::OFS_COUNT0: rdata_next = loop_counter0_reg;
        tss_pkg::OFS_COUNT1: rdata_next = loop_counter1_reg;
        tss_pkg::OFS_CHSEL:  rdata_next[tss_pkg::CHSEL_W-1:0] = adc_channel_select_reg;
        default:             rdata_next = '0;
      endcase
    end
  end

  always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
    if (!RST_N_IN) begin
      rdata_reg <= '0;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign BUS_RDATA_OUT          = rdata_reg;
  assign IRQ_OUT                = irq_reg;
  assign TRIG_OUT               = trig_reg;
  assign ADC_CHANNEL_SELECT_OUT = adc_channel_select_reg;
  assign BUSY_OUT               = (state_reg != tss_pkg::ST_IDLE);

endmodule

// ---- bench/tss_sequencer_monitor.sv ----
// checker: port-level timing and pulse properties of the step sequencer
`timescale 1ns/1ns
module tss_sequencer_monitor (
  input wire logic        CLK_IN,
  input wire logic        RST_N_IN,
  input wire logic [7:0]  BUS_ADDR_IN,
  input wire logic [15:0] BUS_WDATA_IN,
  input wire logic        BUS_WR_IN,
  input wire logic        BUS_RD_IN,
  input wire logic [15:0] BUS_RDATA_OUT,
  input wire logic [15:0] TRIG_SRC_IN,
  input wire logic [15:0] IRQ_OUT,
  input wire logic [31:0] TRIG_OUT,
  input wire logic [4:0]  ADC_CHANNEL_SELECT_OUT,
  input wire logic        BUSY_OUT
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  ////////////////////////////////////////////////////////////////////////////
  sequence s_run_req;
    BUS_WR_IN && BUS_ADDR_IN == tss_pkg::OFS_CTRL && BUS_WDATA_IN[0] && !BUSY_OUT;
  endsequence
  sequence s_fetch_exec;
    BUSY_OUT [*2];
  endsequence
  // run_reg is set at the write edge, the state leaves idle one edge later
  property p_start; s_run_req |-> ##2 s_fetch_exec; endproperty
  a_start: assert property (p_start) else $error("run write did not fetch");
  property p_irq_one; $onehot0(IRQ_OUT); endproperty
  a_irq_one: assert property (p_irq_one) else $error("several irq lines");
  property p_trig_one; $onehot0(TRIG_OUT); endproperty
  a_trig_one: assert property (p_trig_one) else $error("several triggers");
  property p_irq_pulse; (|IRQ_OUT) |=> IRQ_OUT == 16'h0000; endproperty
  a_irq_pulse: assert property (p_irq_pulse) else $error("irq held too long");
  property p_trig_pulse; (|TRIG_OUT) |=> TRIG_OUT == 32'h0000_0000; endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger held");
  property p_irq_cause; (|IRQ_OUT) |-> $past(BUSY_OUT); endproperty
  a_irq_cause: assert property (p_irq_cause) else $error("irq while idle");
  property p_chsel_cause; !$stable(ADC_CHANNEL_SELECT_OUT) |-> $past(BUSY_OUT); endproperty
  a_chsel_cause: assert property (p_chsel_cause) else $error("channel moved idle");
  property p_idle_quiet; !BUSY_OUT [*3] |-> TRIG_OUT == 32'h0000_0000; endproperty
  a_idle_quiet: assert property (p_idle_quiet) else $error("trigger while idle");
  property p_rd_window; !$past(BUS_RD_IN) |-> BUS_RDATA_OUT == 16'h0000; endproperty
  a_rd_window: assert property (p_rd_window) else $error("read data outside window");
  property p_rd_unmapped; BUS_RD_IN && BUS_ADDR_IN > 8'h09 |=> BUS_RDATA_OUT == 16'h0000;
  endproperty
  a_rd_unmapped: assert property (p_rd_unmapped) else $error("unmapped read not zero");
endmodule
bind tss_sequencer tss_sequencer_monitor tss_sequencer_monitor_inst (
  .CLK_IN(CLK_IN), .RST_N_IN(RST_N_IN), .BUS_ADDR_IN(BUS_ADDR_IN),
  .BUS_WDATA_IN(BUS_WDATA_IN), .BUS_WR_IN(BUS_WR_IN), .BUS_RD_IN(BUS_RD_IN),
  .BUS_RDATA_OUT(BUS_RDATA_OUT), .TRIG_SRC_IN(TRIG_SRC_IN), .IRQ_OUT(IRQ_OUT),
  .TRIG_OUT(TRIG_OUT), .ADC_CHANNEL_SELECT_OUT(ADC_CHANNEL_SELECT_OUT), .BUSY_OUT(BUSY_OUT)
);

// ---- bench/tss_periph_model.sv ----
// partner: peripherals that drive trigger sources and log request pulses
`timescale 1ns/1ns
module tss_periph_model (
  input  wire logic        clk_in,
  input  wire logic        rst_n_in,
  input  wire logic        clr_in,
  input  wire logic [15:0] lvl_in,
  input  wire logic [15:0] irq_in,
  input  wire logic [31:0] trig_in,
  output logic      [15:0] src_out,
  output logic      [15:0] irq_seen_out,
  output logic      [31:0] trig_seen_out,
  output logic      [7:0]  irq_cnt_out,
  output logic      [7:0]  trig_cnt_out
);
  // sources change only on the clock, as synchronous levels
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      src_out       <= 16'h0000;
      irq_seen_out  <= 16'h0000;
      trig_seen_out <= 32'h0000_0000;
      irq_cnt_out   <= 8'h00;
      trig_cnt_out  <= 8'h00;
    end else if (clr_in) begin
      src_out       <= lvl_in;
      irq_seen_out  <= 16'h0000;
      trig_seen_out <= 32'h0000_0000;
      irq_cnt_out   <= 8'h00;
      trig_cnt_out  <= 8'h00;
    end else begin
      src_out       <= lvl_in;
      irq_seen_out  <= irq_seen_out | irq_in;
      trig_seen_out <= trig_seen_out | trig_in;
      irq_cnt_out   <= irq_cnt_out + 8'($countones(irq_in));
      trig_cnt_out  <= trig_cnt_out + 8'($countones(trig_in));
    end
  end
endmodule

// ---- bench/tss_sequencer_bench.sv ----
// testbench: register, step code, loop and wait scenarios for the sequencer
`timescale 1ns/1ns
module tss_sequencer_bench;
  logic        clk, rst_n, wr, rd, clr, busy;
  logic [7:0]  addr, irq_cnt, trig_cnt;
  logic [15:0] wdata, rdata, lvl, src, irq, irq_seen;
  logic [31:0] trig, trig_seen;
  logic [4:0]  chsel;
  int          n_mismatch, samples_checked, cycles;

  tss_sequencer tss_sequencer_inst (
    .CLK_IN(clk), .RST_N_IN(rst_n), .BUS_ADDR_IN(addr), .BUS_WDATA_IN(wdata),
    .BUS_WR_IN(wr), .BUS_RD_IN(rd), .BUS_RDATA_OUT(rdata), .TRIG_SRC_IN(src),
    .IRQ_OUT(irq), .TRIG_OUT(trig), .ADC_CHANNEL_SELECT_OUT(chsel), .BUSY_OUT(busy));
  tss_periph_model tss_periph_model_inst (
    .clk_in(clk), .rst_n_in(rst_n), .clr_in(clr), .lvl_in(lvl), .irq_in(irq),
    .trig_in(trig), .src_out(src), .irq_seen_out(irq_seen), .trig_seen_out(trig_seen),
    .irq_cnt_out(irq_cnt), .trig_cnt_out(trig_cnt));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic bus_wr(input logic [7:0] a, input logic [15:0] d);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic bus_rd(input logic [7:0] a, input logic [15:0] exp);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 chk({16'h0000, rdata}, {16'h0000, exp});
    @(posedge clk);
  endtask
  task automatic step(input logic [4:0] n, input logic [7:0] s);
    bus_wr({tss_pkg::OFS_QUEUE_PFX, n}, {8'h00, s});
  endtask
  task automatic start(input logic [4:0] p);
    clr <= 1'b1;
    bus_wr(tss_pkg::OFS_QPTR, {11'h000, p});
    clr <= 1'b0;
    bus_wr(tss_pkg::OFS_CTRL, 16'h0001);
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    #1;
    while (busy !== 1'b0 && k < 400) begin
      @(posedge clk);
      #1 k++;
    end
    chk({31'h0, busy}, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 10; a++)
      bus_rd(a[7:0], 16'h0000);
    bus_wr(tss_pkg::OFS_ADJUST, 16'hA5C3);
    bus_rd(tss_pkg::OFS_ADJUST, 16'hA5C3);
    bus_wr(tss_pkg::OFS_COUNT1, 16'h0003);
    bus_rd(tss_pkg::OFS_COUNT1, 16'h0003);
    bus_wr(tss_pkg::OFS_COUNT1, 16'h0000);
    bus_rd(tss_pkg::OFS_COUNT1, 16'h0000);
    bus_wr(tss_pkg::OFS_STATUS, 16'hFFFF);
    bus_rd(tss_pkg::OFS_STATUS, 16'h0000);
    bus_rd(8'h0A, 16'h0000);
    bus_wr(8'h20, 16'h00FF);
    bus_rd(8'h20, 16'h0000);
    $display("t_regs done");
  endtask
  task automatic t_codes();
    step(5'd0, 8'h73);
    step(5'd1, 8'h35);
    step(5'd2, 8'h92);
    step(5'd3, 8'h87);
    step(5'd4, 8'h60);
    step(5'd5, 8'h00);
    step(5'd6, 8'h15);
    step(5'd7, 8'h24);
    step(5'd8, 8'h01);
    start(5'd0);
    wait_idle();
    chk({16'h0, irq_seen}, 32'h0000_0008);
    chk(trig_seen, 32'h0004_0080);
    chk({24'h0, trig_cnt}, 32'h2);
    chk({27'h0, chsel}, 32'h4);
    bus_rd(tss_pkg::OFS_QPTR, 16'h0009);
    bus_rd(tss_pkg::OFS_CTRL, 16'h0000);
    $display("t_codes done");
  endtask
  task automatic t_addcopy();
    bus_wr(tss_pkg::OFS_ADJUST, 16'h0005);
    bus_wr(tss_pkg::OFS_HOLD, 16'h0009);
    step(5'd10, 8'h10);
    step(5'd11, 8'h10);
    step(5'd12, 8'h19);
    step(5'd13, 8'h01);
    start(5'd10);
    wait_idle();
    bus_rd(tss_pkg::OFS_LIMIT0, 16'h000A);
    bus_rd(tss_pkg::OFS_LIMIT1, 16'h0009);
    bus_rd(tss_pkg::OFS_QPTR, 16'h000E);
    $display("t_addcopy done");
  endtask
  task automatic t_loops();
    bus_wr(tss_pkg::OFS_LIMIT0, 16'h0002);
    bus_wr(tss_pkg::OFS_LIMIT1, 16'h0001);
    step(5'd0, 8'h81);
    step(5'd1, 8'hC0);
    step(5'd2, 8'h82);
    step(5'd3, 8'hE2);
    step(5'd4, 8'h01);
    start(5'd0);
    wait_idle();
    chk({24'h0, trig_cnt}, 32'h5);
    chk(trig_seen, 32'h0000_0006);
    bus_rd(tss_pkg::OFS_COUNT0, 16'h0000);
    bus_rd(tss_pkg::OFS_COUNT1, 16'h0000);
    bus_rd(tss_pkg::OFS_QPTR, 16'h0005);
    $display("t_loops done");
  endtask
  task automatic t_jump();
    step(5'd0, 8'hB3);
    step(5'd1, 8'h70);
    step(5'd19, 8'h7F);
    step(5'd20, 8'h35);
    step(5'd21, 8'h01);
    start(5'd0);
    wait_idle();
    chk({16'h0, irq_seen}, 32'h0000_8000);
    chk({27'h0, chsel}, 32'h15);
    bus_rd(tss_pkg::OFS_QPTR, 16'h0016);
    $display("t_jump done");
  endtask
  task automatic t_wait();
    step(5'd0, 8'h42);
    step(5'd1, 8'h52);
    step(5'd2, 8'h71);
    step(5'd3, 8'h01);
    start(5'd0);
    bus_wr(tss_pkg::OFS_QPTR, 16'h0009);
    bus_rd(tss_pkg::OFS_QPTR, 16'h0000);
    lvl <= 16'h0008;
    repeat (6) @(posedge clk);
    bus_rd(tss_pkg::OFS_STATUS, 16'h0003);
    lvl <= 16'h000C;
    repeat (6) @(posedge clk);
    bus_rd(tss_pkg::OFS_STATUS, 16'h0103);
    chk({24'h0, irq_cnt}, 32'h0);
    lvl <= 16'h0008;
    wait_idle();
    chk({16'h0, irq_seen}, 32'h0000_0002);
    bus_rd(tss_pkg::OFS_QPTR, 16'h0004);
    $display("t_wait done");
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic close_out();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      n_mismatch++;
      close_out();
    end
  end
  initial begin
    {rst_n, wr, rd, clr, addr, wdata, lvl} = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    t_regs();
    t_codes();
    t_addcopy();
    t_loops();
    t_jump();
    t_wait();
    close_out();
  end
endmodule
